// >>> src/pll_steer_pkg.sv
// Constants, register map and carrier types of the divider steering block.
// Assumes a 32-bit APB master and a VCO/2 tick strobe synchronous to pclk.
package pll_steer_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FB_LO  = 8'h08;
  localparam logic [7:0] OFF_FB_HI  = 8'h0c;
  localparam logic [7:0] OFF_FB_REM = 8'h10;
  localparam logic [7:0] OFF_FB_DEN = 8'h14;
  localparam logic [7:0] OFF_FB_BP  = 8'h18;
  localparam logic [7:0] OFF_FR_LO  = 8'h1c;
  localparam logic [7:0] OFF_FR_HI  = 8'h20;
  localparam logic [7:0] OFF_FR_REM = 8'h24;
  localparam logic [7:0] OFF_FR_DEN = 8'h28;
  localparam logic [7:0] OFF_FR_BP  = 8'h2c;
  localparam logic [7:0] OFF_STEP   = 8'h30;
  // ****************************************************************
  // Control fields
  // ****************************************************************
  localparam int CTRL_FRAC_EN   = 0;
  localparam int CTRL_STEP_EN   = 1;
  localparam int CTRL_LIVE_RD   = 2;
  localparam int CTRL_USE_FRAC  = 3;
  localparam int CTRL_SPREAD_EN = 4;
  localparam int CTRL_INC_SEL   = 8;
  localparam int CTRL_DEC_SEL   = 12;
  localparam int SEL_W          = 2;
  localparam logic [15:0] CTRL_WMASK = 16'h331f;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int FB_W       = 42;
  localparam int FR_W       = 40;
  localparam int FR_FRAC_W  = 36;
  localparam int REM_W      = 32;
  localparam int BP_W       = 6;
  localparam int STEP_W     = 24;
  localparam int STEP_SHIFT = 7;
  localparam logic [REM_W-1:0] DEN_RST   = 32'h0000_0001;
  localparam logic [4:0]       FRAC_WRAP = 5'h10;
  typedef struct packed {
    logic             enable;
    logic [FR_W-1:0]  div;
    logic [REM_W-1:0] rem;
    logic [REM_W-1:0] den;
    logic [BP_W-1:0]  bp;
  } frac_cfg_t;
  typedef struct packed {
    logic [FB_W-1:0]  div;
    logic [REM_W-1:0] rem;
    logic [REM_W-1:0] den;
    logic [BP_W-1:0]  bp;
  } fb_cfg_t;
endpackage

// >>> src/frac_divider.sv
// Fractional output divider: 4.36 fixed-point ratio plus remainder term.
// Assumes tick pulses once per VCO/2 edge, synchronous to pclk.
`timescale 1ns/10ps
module frac_divider (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    tick,
  input  wire pll_steer_pkg::frac_cfg_t cfg,
  output logic                         clk_out_q
);
  logic [4:0]                      cnt_q, cnt_d, per_q, per_d, base;
  logic [pll_steer_pkg::FR_FRAC_W-1:0] acc_q, acc_d;
  logic [pll_steer_pkg::REM_W-1:0] racc_q, racc_d;
  logic [pll_steer_pkg::REM_W:0]   rsum;
  logic [37:0]                     ext, sum;
  logic                            out_d, wrap;
  always_comb begin
    base = {1'b0, cfg.div[39:36]};
    if (cfg.div[39:36] == 4'h0) begin
      base = pll_steer_pkg::FRAC_WRAP;
    end
    rsum = {1'b0, racc_q} + {1'b0, cfg.rem};
    ext = 38'h0;
    racc_d = rsum[pll_steer_pkg::REM_W-1:0];
    if (rsum >= {1'b0, cfg.den}) begin
      racc_d = 32'(rsum - {1'b0, cfg.den});
      ext = 38'h1 << cfg.bp;
    end
    sum = {2'b00, acc_q} + {2'b00, cfg.div[35:0]} + ext;
    wrap = (cnt_q >= 5'(per_q - 5'h1));
    cnt_d = cnt_q;
    per_d = per_q;
    acc_d = acc_q;
    out_d = clk_out_q;
    if (!cfg.enable) begin
      cnt_d = 5'h0;
      per_d = pll_steer_pkg::FRAC_WRAP;
      acc_d = 36'h0;
      racc_d = 32'h0;
      out_d = 1'b0;
    end else if (tick) begin
      if (wrap) begin
        cnt_d = 5'h0;
        per_d = 5'(base + {3'b000, sum[37:36]});
        acc_d = sum[35:0];
      end else begin
        cnt_d = 5'(cnt_q + 5'h1);
        racc_d = racc_q;
      end
      // Duty is uneven for odd periods; follow with an even divider
      out_d = (cnt_d < (per_d >> 1));
    end else begin
      racc_d = racc_q;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h0;
      per_q <= pll_steer_pkg::FRAC_WRAP;
      acc_q <= 36'h0;
      racc_q <= 32'h0;
      clk_out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      per_q <= per_d;
      acc_q <= acc_d;
      racc_q <= racc_d;
      clk_out_q <= out_d;
    end
  end
  property p_frac_off;
    @(posedge pclk) disable iff (!presetn)
    !cfg.enable |=> (!clk_out_q && cnt_q == 5'h0);
  endproperty
  a_frac_off: assert property (p_frac_off) else $error("divider ran while off");
  property p_wrap16;
    @(posedge pclk) disable iff (!presetn)
    cfg.enable && tick && wrap && cfg.div[39:36] == 4'h0 && sum[37:36] == 2'b00
      |=> per_q == 5'h10;
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("zero ratio not 16");
  property p_tick_only;
    @(posedge pclk) disable iff (!presetn)
    cfg.enable && !tick ##1 cfg.enable |-> $stable(cnt_q);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("count moved without tick");
endmodule // frac_divider

// >>> src/pll_steer_top.sv
// APB register block steering feedback and fractional divider values.
// Assumes pll_locked and the triggers are synchronous levels to pclk.
//
// How it works
// - Fractional divider runs only when enabled
// - Ratio is div plus scaled remainder fraction
// - Fractional divider counts VCO/2 ticks
// - Fractional value has four integer bits
// - Zero ratio with denominator one divides sixteen
// - Feedback value writable, effective on high-word write
// - Fractional value writable, effective on high-word write
// - Triggers add or subtract shifted step
// - Readback select picks live or nominal
// - Steps applied only while locked
// - Relock restores live value to nominal
// - Stepping and spread never share step register
// - Step disable forces live back to nominal
// - Status shows live lock state
`timescale 1ns/10ps
module pll_steer_top #(
  parameter int N_TRIG = 4
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata_q,
  output logic                         pready_q,
  output logic                         pslverr_q,
  input  wire logic                    pll_locked,
  input  wire logic [N_TRIG-1:0]       inc_trig,
  input  wire logic [N_TRIG-1:0]       dec_trig,
  input  wire logic                    vco_half_tick,
  output pll_steer_pkg::fb_cfg_t       fb_cfg_q,
  output logic                         frac_clk_q
);
  // ****************************************************************
  // State
  // ****************************************************************
  localparam int FB_W = pll_steer_pkg::FB_W;
  localparam int FR_W = pll_steer_pkg::FR_W;
  localparam int RW   = pll_steer_pkg::REM_W;
  localparam int BW   = pll_steer_pkg::BP_W;
  localparam int SEL_W_L = pll_steer_pkg::SEL_W;
  logic [15:0]       ctrl_q, ctrl_d;
  logic              locked_q, lock_prev_q;
  logic [FB_W-1:0]   fb_nom_q, fb_nom_d, fb_live_q, fb_live_d, delta;
  logic [31:0]       fb_stage_q, fb_stage_d, fr_stage_q, fr_stage_d;
  logic [FR_W-1:0]   fr_nom_q, fr_nom_d;
  logic [RW-1:0]     fb_rem_q, fb_rem_d, fb_den_q, fb_den_d;
  logic [RW-1:0]     fr_rem_q, fr_rem_d, fr_den_q, fr_den_d;
  logic [BW-1:0]     fb_bp_q, fb_bp_d, fr_bp_q, fr_bp_d;
  logic [pll_steer_pkg::STEP_W-1:0] step_q, step_d;
  logic [N_TRIG-1:0] inc_s1_q, inc_s2_q, inc_s3_q;
  logic [N_TRIG-1:0] dec_s1_q, dec_s2_q, dec_s3_q;
  logic [31:0]       rd_d;
  logic [FB_W-1:0]   fb_view;
  logic              hit, wr, fb_commit, relock, inc_ev, dec_ev, step_ok;
  logic [SEL_W_L-1:0] isel, dsel;
  pll_steer_pkg::frac_cfg_t fr_cfg;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign wr = psel && penable && pready_q && pwrite;
  assign fb_commit = wr && (paddr == pll_steer_pkg::OFF_FB_HI);
  assign isel = ctrl_q[pll_steer_pkg::CTRL_INC_SEL +: SEL_W_L];
  assign dsel = ctrl_q[pll_steer_pkg::CTRL_DEC_SEL +: SEL_W_L];
  assign fb_view = ctrl_q[pll_steer_pkg::CTRL_LIVE_RD] ? fb_live_q : fb_nom_q;

  always_comb begin
    rd_d = 32'h0;
    hit = 1'b1;
    case (paddr)
      pll_steer_pkg::OFF_CTRL:   rd_d = {16'h0, ctrl_q};
      pll_steer_pkg::OFF_STATUS: rd_d = {31'h0, locked_q};
      pll_steer_pkg::OFF_FB_LO:  rd_d = fb_view[31:0];
      pll_steer_pkg::OFF_FB_HI:  rd_d = {22'h0, fb_view[FB_W-1:32]};
      pll_steer_pkg::OFF_FB_REM: rd_d = fb_rem_q;
      pll_steer_pkg::OFF_FB_DEN: rd_d = fb_den_q;
      pll_steer_pkg::OFF_FB_BP:  rd_d = {26'h0, fb_bp_q};
      pll_steer_pkg::OFF_FR_LO:  rd_d = fr_nom_q[31:0];
      pll_steer_pkg::OFF_FR_HI:  rd_d = {24'h0, fr_nom_q[FR_W-1:32]};
      pll_steer_pkg::OFF_FR_REM: rd_d = fr_rem_q;
      pll_steer_pkg::OFF_FR_DEN: rd_d = fr_den_q;
      pll_steer_pkg::OFF_FR_BP:  rd_d = {26'h0, fr_bp_q};
      pll_steer_pkg::OFF_STEP:   rd_d = {8'h0, step_q};
      default:                   hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      // One wait-free access phase: answer prepared in the setup cycle
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !hit;
      prdata_q <= (psel && !penable && !pwrite) ? rd_d : 32'h0;
    end
  end

  // ****************************************************************
  // Registers written by software
  // ****************************************************************
  always_comb begin
    ctrl_d = ctrl_q;
    fb_nom_d = fb_nom_q;
    fb_stage_d = fb_stage_q;
    fr_stage_d = fr_stage_q;
    fr_nom_d = fr_nom_q;
    fb_rem_d = fb_rem_q;
    fb_den_d = fb_den_q;
    fb_bp_d = fb_bp_q;
    fr_rem_d = fr_rem_q;
    fr_den_d = fr_den_q;
    fr_bp_d = fr_bp_q;
    step_d = step_q;
    if (wr) begin
      case (paddr)
        pll_steer_pkg::OFF_CTRL:   ctrl_d = pwdata[15:0] & pll_steer_pkg::CTRL_WMASK;
        pll_steer_pkg::OFF_FB_LO:  fb_stage_d = pwdata;
        pll_steer_pkg::OFF_FB_HI:  fb_nom_d = {pwdata[FB_W-33:0], fb_stage_q};
        pll_steer_pkg::OFF_FB_REM: fb_rem_d = pwdata;
        pll_steer_pkg::OFF_FB_DEN: fb_den_d = pwdata;
        pll_steer_pkg::OFF_FB_BP:  fb_bp_d = pwdata[BW-1:0];
        pll_steer_pkg::OFF_FR_LO:  fr_stage_d = pwdata;
        pll_steer_pkg::OFF_FR_HI:  fr_nom_d = {pwdata[FR_W-33:0], fr_stage_q};
        pll_steer_pkg::OFF_FR_REM: fr_rem_d = pwdata;
        pll_steer_pkg::OFF_FR_DEN: fr_den_d = pwdata;
        pll_steer_pkg::OFF_FR_BP:  fr_bp_d = pwdata[BW-1:0];
        pll_steer_pkg::OFF_STEP:   step_d = pwdata[pll_steer_pkg::STEP_W-1:0];
        default:                   ctrl_d = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= pll_steer_pkg::CTRL_RST;
      fb_nom_q <= 42'h0;
      fb_stage_q <= 32'h0;
      fr_stage_q <= 32'h0;
      fr_nom_q <= 40'h0;
      fb_rem_q <= 32'h0;
      fb_den_q <= pll_steer_pkg::DEN_RST;
      fb_bp_q <= 6'h0;
      fr_rem_q <= 32'h0;
      fr_den_q <= pll_steer_pkg::DEN_RST;
      fr_bp_q <= 6'h0;
      step_q <= 24'h0;
    end else begin
      ctrl_q <= ctrl_d;
      fb_nom_q <= fb_nom_d;
      fb_stage_q <= fb_stage_d;
      fr_stage_q <= fr_stage_d;
      fr_nom_q <= fr_nom_d;
      fb_rem_q <= fb_rem_d;
      fb_den_q <= fb_den_d;
      fb_bp_q <= fb_bp_d;
      fr_rem_q <= fr_rem_d;
      fr_den_q <= fr_den_d;
      fr_bp_q <= fr_bp_d;
      step_q <= step_d;
    end
  end

  // ****************************************************************
  // Trigger synchronisers and stepping
  // ****************************************************************
  // one event per change
  assign inc_ev = inc_s2_q[isel] ^ inc_s3_q[isel];
  assign dec_ev = dec_s2_q[dsel] ^ dec_s3_q[dsel];
  assign relock = locked_q && !lock_prev_q;
  assign step_ok = ctrl_q[pll_steer_pkg::CTRL_STEP_EN] && locked_q
                   && !ctrl_q[pll_steer_pkg::CTRL_SPREAD_EN]
                   && !ctrl_q[pll_steer_pkg::CTRL_USE_FRAC];
  assign delta = {11'h0, step_q, 7'h0};

  always_comb begin
    fb_live_d = fb_live_q;
    if (fb_commit) begin
      fb_live_d = fb_nom_d;
    end else if (!ctrl_d[pll_steer_pkg::CTRL_STEP_EN] || relock) begin
      fb_live_d = fb_nom_q;
    end else if (step_ok && inc_ev && !dec_ev) begin
      fb_live_d = 42'(fb_live_q + delta);
    end else if (step_ok && dec_ev && !inc_ev) begin
      fb_live_d = 42'(fb_live_q - delta);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_live_q <= 42'h0;
      locked_q <= 1'b0;
      lock_prev_q <= 1'b0;
      inc_s1_q <= '0;
      inc_s2_q <= '0;
      inc_s3_q <= '0;
      dec_s1_q <= '0;
      dec_s2_q <= '0;
      dec_s3_q <= '0;
    end else begin
      fb_live_q <= fb_live_d;
      locked_q <= pll_locked;
      lock_prev_q <= locked_q;
      inc_s1_q <= inc_trig;
      inc_s2_q <= inc_s1_q;
      inc_s3_q <= inc_s2_q;
      dec_s1_q <= dec_trig;
      dec_s2_q <= dec_s1_q;
      dec_s3_q <= dec_s2_q;
    end
  end

  assign fb_cfg_q = {fb_live_q, fb_rem_q, fb_den_q, fb_bp_q};

  // ****************************************************************
  // Fractional output divider
  // ****************************************************************
  assign fr_cfg = {ctrl_q[pll_steer_pkg::CTRL_FRAC_EN], fr_nom_q, fr_rem_q, fr_den_q, fr_bp_q};
  frac_divider u_frac (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (vco_half_tick),
    .cfg       (fr_cfg),
    .clk_out_q (frac_clk_q)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_commit;
    @(posedge pclk) disable iff (!presetn)
    fb_commit |=> fb_nom_q == {$past(pwdata[9:0]), $past(fb_stage_q)};
  endproperty
  a_commit: assert property (p_commit) else $error("feedback not committed whole");
  property p_inc;
    @(posedge pclk) disable iff (!presetn)
    step_ok && inc_ev && !dec_ev && !fb_commit && !relock && ctrl_d[1]
      |=> fb_live_q == 42'($past(fb_live_q) + {11'h0, $past(step_q), 7'h0});
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_unlocked;
    @(posedge pclk) disable iff (!presetn)
    !locked_q && !fb_commit && ctrl_d[1] |=> $stable(fb_live_q);
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("stepped while unlocked");
  property p_relock;
    @(posedge pclk) disable iff (!presetn)
    !lock_prev_q && locked_q |=> fb_live_q == fb_nom_q;
  endproperty
  a_relock: assert property (p_relock) else $error("relock kept steps");
  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q[1] |-> fb_live_q == fb_nom_q;
  endproperty
  a_disabled: assert property (p_disabled) else $error("live differs while disabled");
  property p_readback;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == 8'h08 && ctrl_q[2]
      |=> prdata_q == $past(fb_live_q[31:0]);
  endproperty
  a_readback: assert property (p_readback) else $error("live readback wrong");
  property p_spread;
    @(posedge pclk) disable iff (!presetn)
    ctrl_q[4] && !fb_commit && !relock && ctrl_d[1] |=> $stable(fb_live_q);
  endproperty
  a_spread: assert property (p_spread) else $error("stepped during spread");
  property p_sync;
    @(posedge pclk) disable iff (!presetn)
    (inc_trig[isel] != $past(inc_trig[isel])) && $stable(isel)
      ##1 $stable(isel) ##1 $stable(isel) |-> inc_ev;
  endproperty
  a_sync: assert property (p_sync) else $error("trigger change lost");
  property p_status;
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == 8'h04 |=> prdata_q[0] == $past(locked_q);
  endproperty
  a_status: assert property (p_status) else $error("lock status wrong");
endmodule // pll_steer_top

// >>> src/dummy_never.sv
// Holds no logic: the block is pll_steer_top and the frac_divider it instantiates.

// >>> verification/tb.sv
// Self-checking bench for the divider steering block: APB, stepping, lock, divider.
// Assumes the package and design sources under src/ are compiled first.
`timescale 1ns/10ps
module tb;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic                   pclk          = 1'b0;
  logic                   presetn       = 1'b0;
  logic                   psel          = 1'b0;
  logic                   penable       = 1'b0;
  logic                   pwrite        = 1'b0;
  logic [7:0]             paddr         = 8'h00;
  logic [31:0]            pwdata        = 32'h0;
  logic                   pll_locked    = 1'b1;
  logic [3:0]             inc_trig      = 4'h0;
  logic [3:0]             dec_trig      = 4'h0;
  logic                   vco_half_tick = 1'b0;
  logic [31:0]            prdata_q;
  logic                   pready_q;
  logic                   pslverr_q;
  logic                   frac_clk_q;
  pll_steer_pkg::fb_cfg_t fb_cfg_q;
  int                     miscompares   = 0;
  int                     comparisons   = 0;
  int                     cyc           = 0;
  int                     tick_div      = 1;
  localparam logic [41:0] NOM  = 42'h2ab_1234_5678;
  localparam logic [41:0] STEP = 42'h000_0008_0080;

  pll_steer_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .pll_locked(pll_locked), .inc_trig(inc_trig),
    .dec_trig(dec_trig), .vco_half_tick(vco_half_tick), .fb_cfg_q(fb_cfg_q),
    .frac_clk_q(frac_clk_q)
  );

  always #12.5 pclk = ~pclk;

  // Divider tick strobe: every cycle, or every other cycle for a halved rate
  always @(posedge pclk) begin
    vco_half_tick <= (tick_div == 1) ? 1'b1 : ~vco_half_tick;
  end

  // Hang guard, well above the fewer than a thousand cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until pready is seen high; reply taken in that same cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready_q !== 1'b1);
    rd  = prdata_q;
    err = pslverr_q;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(w, exp, r);
  endtask

  task automatic chkdiv(input string w, input logic [41:0] exp);
    repeat (2) @(negedge pclk);
    chk(w, exp, fb_cfg_q.div);
  endtask

  // One change of state on a trigger line, then enough edges for the step
  task automatic trg(input bit dec, input int b);
    @(posedge pclk);
    if (dec)
      dec_trig[b] <= ~dec_trig[b];
    else
      inc_trig[b] <= ~inc_trig[b];
    repeat (6) @(posedge pclk);
  endtask

  task automatic rise(output int n);
    logic p;
    n = 0;
    do begin
      p = frac_clk_q;
      @(negedge pclk);
      n++;
    end while (!(p === 1'b0 && frac_clk_q === 1'b1));
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rdc("ctrl", pll_steer_pkg::OFF_CTRL, 32'h0);
    rdc("fb_den", pll_steer_pkg::OFF_FB_DEN, 32'h1);
    rdc("fr_den", pll_steer_pkg::OFF_FR_DEN, 32'h1);
    chk("fb_cfg den", 32'h1, fb_cfg_q.den);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("unmapped err", 1'b1, e);
    chk("unmapped data", 32'h0, r);
  endtask

  task automatic t_commit;
    wr(pll_steer_pkg::OFF_FB_LO, NOM[31:0]);
    chkdiv("div staged", 42'h0);
    wr(pll_steer_pkg::OFF_FB_REM, 32'h0000_0005);
    wr(pll_steer_pkg::OFF_FB_BP, 32'h0000_002a);
    @(negedge pclk);
    chk("fb_cfg rem", 32'h5, fb_cfg_q.rem);
    chk("fb_cfg bp", 6'h2a, fb_cfg_q.bp);
    wr(pll_steer_pkg::OFF_FB_REM, 32'h0);
    wr(pll_steer_pkg::OFF_FB_BP, 32'h0);
    rdc("fb den", pll_steer_pkg::OFF_FB_DEN, 32'h1);
    wr(pll_steer_pkg::OFF_FB_HI, {22'h0, NOM[41:32]});
    chkdiv("div commit", NOM);
  endtask

  task automatic t_step;
    wr(pll_steer_pkg::OFF_STEP, 32'h0000_1001);
    wr(pll_steer_pkg::OFF_CTRL, 32'h0000_1206);
    trg(1'b0, 2);
    chkdiv("inc rise", NOM + STEP);
    trg(1'b0, 2);
    chkdiv("inc fall", NOM + 2 * STEP);
    trg(1'b0, 0);
    chkdiv("unselected", NOM + 2 * STEP);
    trg(1'b1, 1);
    chkdiv("dec", NOM + STEP);
    rdc("live rd", pll_steer_pkg::OFF_FB_LO, NOM[31:0] + STEP[31:0]);
    wr(pll_steer_pkg::OFF_CTRL, 32'h0000_1202);
    rdc("nominal rd", pll_steer_pkg::OFF_FB_LO, NOM[31:0]);
    wr(pll_steer_pkg::OFF_CTRL, 32'h0000_1206);
  endtask

  task automatic t_lock;
    @(posedge pclk);
    pll_locked <= 1'b0;
    trg(1'b0, 2);
    chkdiv("unlocked", NOM + STEP);
    rdc("status off", pll_steer_pkg::OFF_STATUS, 32'h0);
    @(posedge pclk);
    pll_locked <= 1'b1;
    repeat (2) @(posedge pclk);
    chkdiv("relock", NOM);
    rdc("status on", pll_steer_pkg::OFF_STATUS, 32'h1);
  endtask

  task automatic t_block;
    logic [31:0] c [2] = '{32'h0000_1216, 32'h0000_120e};
    for (int i = 0; i < 2; i++) begin
      wr(pll_steer_pkg::OFF_CTRL, c[i]);
      trg(1'b0, 2);
      chkdiv("blocked", NOM);
    end
    wr(pll_steer_pkg::OFF_CTRL, 32'h0000_1206);
    trg(1'b0, 2);
    chkdiv("stepped", NOM + STEP);
    trg(1'b1, 1);
    chkdiv("stepped back", NOM);
    trg(1'b0, 2);
    chkdiv("stepped again", NOM + STEP);
    wr(pll_steer_pkg::OFF_CTRL, 32'h0000_1204);
    chkdiv("disable", NOM);
  endtask

  // Cases: 5.0, 5.5, 5.0 plus remainder half, wrapped 16.0, 5.0 at half tick rate
  task automatic t_frac;
    logic [7:0]  hi [5] = '{8'h50, 8'h58, 8'h50, 8'h00, 8'h50};
    logic [31:0] rm [5] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
    logic [31:0] bp [5] = '{32'h0, 32'h0, 32'h23, 32'h0, 32'h0};
    int          td [5] = '{1, 1, 1, 1, 2};
    int          ex [5] = '{10, 11, 11, 32, 20};
    int          n0;
    int          n1;
    int          n2;
    int          n3;
    for (int i = 0; i < 5; i++) begin
      tick_div = td[i];
      wr(pll_steer_pkg::OFF_FR_LO, 32'h0);
      wr(pll_steer_pkg::OFF_FR_REM, rm[i]);
      wr(pll_steer_pkg::OFF_FR_DEN, 32'h1);
      wr(pll_steer_pkg::OFF_FR_BP, bp[i]);
      wr(pll_steer_pkg::OFF_FR_HI, {24'h0, hi[i]});
      rdc("fr hi", pll_steer_pkg::OFF_FR_HI, {24'h0, hi[i]});
      wr(pll_steer_pkg::OFF_CTRL, 32'h0000_0001);
      // The period running at enable is the idle one of sixteen; skip it
      rise(n0);
      rise(n1);
      rise(n2);
      rise(n3);
      chk("two periods", ex[i], n2 + n3);
      wr(pll_steer_pkg::OFF_CTRL, 32'h0);
      repeat (2) @(negedge pclk);
      n0 = 0;
      repeat (40) begin
        @(negedge pclk);
        n0 += (frac_clk_q !== 1'b0);
      end
      chk("disabled out", 0, n0);
    end
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_commit();
    t_step();
    t_lock();
    t_block();
    t_frac();
    results();
  end
endmodule // tb
